// [include/pecb_pkg.sv]
package pecb_pkg;

  // management register numbers of the indirect window
  localparam logic [4:0]  MGMT_INDIRECT_ADDR = 5'h1E;
  localparam logic [4:0]  MGMT_INDIRECT_DATA = 5'h1F;

  // extended register addresses
  localparam logic [15:0] EXT_TEN_MEG_POWER  = 16'h200A;
  localparam logic [15:0] EXT_IF_COMBO       = 16'h4000;
  localparam logic [15:0] EXT_PAD_CONTROL    = 16'h4001;
  localparam logic [15:0] EXT_COMBO2         = 16'h4003;
  localparam logic [15:0] EXT_WAKE_ADDR_HIGH = 16'h4004;
  localparam logic [15:0] EXT_WAKE_ADDR_MID  = 16'h4005;
  localparam logic [15:0] EXT_WAKE_ADDR_LOW  = 16'h4006;

  // reset values (clock direction bit is overlaid from its strap)
  localparam logic [15:0] RST_TEN_MEG_POWER  = 16'hCA02;
  localparam logic [15:0] RST_IF_COMBO       = 16'h0000;
  localparam logic [15:0] RST_PAD_CONTROL    = 16'h80EF;
  localparam logic [15:0] RST_COMBO2         = 16'h0260;
  localparam logic [15:0] RST_WAKE_ADDR      = 16'h0000;
  localparam logic [15:0] RST_INDIRECT_ADDR  = 16'h0000;

  // field positions
  localparam int IDLE_DAC_SHUTOFF_BIT   = 10;
  localparam int FAR_LOOP_BIT           = 11;
  localparam int LONG_FRAME_BIT         = 5;
  localparam int CARRIER_PAD_SRC_BIT    = 4;
  localparam int WAKE_ENABLE_BIT        = 2;
  localparam int REDUCED_IF_BIT         = 1;
  localparam int CLOCK_DIR_BIT          = 0;
  localparam int IRQ_PIN_SRC_BIT        = 15;
  localparam int MAC_DRIVE_LSB          = 4;
  localparam int MGMT_DRIVE_LSB         = 2;
  localparam int JITTER_TEST_BIT        = 14;
  localparam int WAKE_SHAPE_LSB         = 7;
  localparam int ISO_TX_CLK_BIT         = 6;
  localparam int ISO_RX_CLK_BIT         = 5;

  // drive strength forced while in scan mode
  localparam logic [1:0]  SCAN_DRIVE_STRENGTH = 2'h3;

  // accepted frame limits in bytes
  localparam logic [14:0] LONG_FRAME_BYTES  = 15'h4800;
  localparam logic [14:0] SHORT_FRAME_BYTES = 15'h1200;

  // wake interrupt pulse widths
  localparam int CLK_PERIOD_NS      = 25;
  localparam int WAKE_PULSE_A_NS    = 10000;
  localparam int WAKE_PULSE_B_NS    = 100000;
  localparam int WAKE_PULSE_C_NS    = 1000000;
  localparam int WAKE_PULSE_D_NS    = 10000000;
  localparam int WAKE_PULSE_A_CYC   = WAKE_PULSE_A_NS / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_B_CYC   = WAKE_PULSE_B_NS / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_C_CYC   = WAKE_PULSE_C_NS / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_D_CYC   = WAKE_PULSE_D_NS / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W         = 19;

  typedef enum logic [1:0] {
    PECB_MODE_MII,
    PECB_MODE_REVERSE_REDUCED,
    PECB_MODE_SECOND_REDUCED,
    PECB_MODE_FIRST_REDUCED
  } pecb_mode_e;

endpackage : pecb_pkg

// [verilog/pecb_wake_pulse.sv]
`timescale 1ns/1ps
module pecb_wake_pulse #(
  parameter int CYC_A = pecb_pkg::WAKE_PULSE_A_CYC,
  parameter int CYC_B = pecb_pkg::WAKE_PULSE_B_CYC,
  parameter int CYC_C = pecb_pkg::WAKE_PULSE_C_CYC,
  parameter int CYC_D = pecb_pkg::WAKE_PULSE_D_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic       i_fire,
  input  wire logic [1:0] i_width_sel,
  output logic            o_active
);

  logic [pecb_pkg::WAKE_CNT_W-1:0] remain;
  logic [pecb_pkg::WAKE_CNT_W-1:0] load_val;

  always_comb begin
    unique case (i_width_sel)
      2'h0: load_val = pecb_pkg::WAKE_CNT_W'(CYC_A);
      2'h1: load_val = pecb_pkg::WAKE_CNT_W'(CYC_B);
      2'h2: load_val = pecb_pkg::WAKE_CNT_W'(CYC_C);
      2'h3: load_val = pecb_pkg::WAKE_CNT_W'(CYC_D);
    endcase
  end

  // a new event restarts the width rather than being dropped
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      remain <= '0;
    end else if (i_ce) begin
      if (i_fire) begin
        remain <= load_val;
      end else if (remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  assign o_active = (remain != '0);

endmodule : pecb_wake_pulse

// [verilog/pecb_ext_bank.sv]
`timescale 1ns/1ps
module pecb_ext_bank #(
  parameter int WAKE_CYC_A = pecb_pkg::WAKE_PULSE_A_CYC,
  parameter int WAKE_CYC_B = pecb_pkg::WAKE_PULSE_B_CYC,
  parameter int WAKE_CYC_C = pecb_pkg::WAKE_PULSE_C_CYC,
  parameter int WAKE_CYC_D = pecb_pkg::WAKE_PULSE_D_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  // management register port
  input  wire logic        i_mgmt_wr_en,
  input  wire logic        i_mgmt_rd_en,
  input  wire logic [4:0]  i_mgmt_regad,
  input  wire logic [15:0] i_mgmt_wdata,
  output logic [15:0]      o_mgmt_rdata,
  output logic             o_mgmt_rd_valid,
  // straps, sampled after reset release
  input  wire logic        i_strap_clk_dir,
  input  wire logic        i_strap_rxd1,
  // device status
  input  wire logic        i_speed_10m,
  input  wire logic        i_tx_activity,
  input  wire logic        i_isolate,
  input  wire logic        i_scan_mode,
  input  wire logic        i_rx_dv,
  input  wire logic        i_crs_dv_int,
  input  wire logic        i_general_irq,
  input  wire logic        i_wake_pkt_valid,
  input  wire logic [47:0] i_wake_pkt_dest,
  input  wire logic        i_wake_irq_clear,
  // control outputs
  output logic             o_dac_power_down,
  output logic             o_far_loop_en,
  output logic             o_long_frame_en,
  output logic [14:0]      o_frame_limit_bytes,
  output logic             o_crs_dv_pad,
  output logic             o_wake_detect_en,
  output logic [1:0]       o_mac_if_mode,
  output logic             o_txclk_is_input,
  output logic             o_rxclk_is_input,
  output logic             o_rxclk_from_dac,
  output logic [1:0]       o_mac_if_drive_strength,
  output logic [1:0]       o_mgmt_pin_drive_strength,
  output logic             o_led0_is_irq,
  output logic             o_led0_irq,
  output logic             o_wake_irq,
  output logic [47:0]      o_wake_match_addr
);

  logic [15:0] indirect_address_reg;
  logic [15:0] ten_meg_power_control;
  logic [15:0] interface_combo_control;
  logic [15:0] pad_control;
  logic [15:0] secondary_combo_control;
  logic [15:0] wake_address_high;
  logic [15:0] wake_address_middle;
  logic [15:0] wake_address_low;
  logic        strap_taken;
  logic        irq_strap;
  logic        ext_wr;
  logic        ext_hit;
  logic [15:0] ext_rdata;
  logic [15:0] next_rdata;
  logic        wake_event;
  logic        wake_level;
  logic        wake_pulse;
  logic        idle_dac_shutoff_en;
  logic        wake_detect_enable;
  logic        carrier_pad_source_sel;
  logic        irq_pin_source_sel;
  logic [2:0]  wake_irq_shape_sel;
  logic        isolate_tx_clock_input;
  logic        isolate_rx_clock_input;
  logic        clock_dir_in;
  logic [47:0] wake_addr;
  pecb_pkg::pecb_mode_e mode;

  // field views
  assign idle_dac_shutoff_en =
    ten_meg_power_control[pecb_pkg::IDLE_DAC_SHUTOFF_BIT];
  assign wake_detect_enable =
    interface_combo_control[pecb_pkg::WAKE_ENABLE_BIT];
  assign carrier_pad_source_sel =
    interface_combo_control[pecb_pkg::CARRIER_PAD_SRC_BIT];
  assign clock_dir_in =
    interface_combo_control[pecb_pkg::CLOCK_DIR_BIT];
  assign irq_pin_source_sel = pad_control[pecb_pkg::IRQ_PIN_SRC_BIT];
  assign wake_irq_shape_sel =
    secondary_combo_control[pecb_pkg::WAKE_SHAPE_LSB +: 3];
  assign isolate_tx_clock_input =
    secondary_combo_control[pecb_pkg::ISO_TX_CLK_BIT];
  assign isolate_rx_clock_input =
    secondary_combo_control[pecb_pkg::ISO_RX_CLK_BIT];
  assign wake_addr = {wake_address_high, wake_address_middle,
                      wake_address_low};

  // indirect access decode
  assign ext_wr = i_mgmt_wr_en &&
                  (i_mgmt_regad == pecb_pkg::MGMT_INDIRECT_DATA);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      indirect_address_reg <= pecb_pkg::RST_INDIRECT_ADDR;
    end else if (i_ce && i_mgmt_wr_en &&
                 i_mgmt_regad == pecb_pkg::MGMT_INDIRECT_ADDR) begin
      indirect_address_reg <= i_mgmt_wdata;
    end
  end

  // straps settle only after reset, so take them on the first edge out
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_taken <= 1'b0;
      irq_strap   <= 1'b0;
    end else if (i_ce && !strap_taken) begin
      strap_taken <= 1'b1;
      irq_strap   <= i_strap_rxd1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ten_meg_power_control <= pecb_pkg::RST_TEN_MEG_POWER;
    end else if (i_ce && ext_wr &&
                 indirect_address_reg == pecb_pkg::EXT_TEN_MEG_POWER) begin
      ten_meg_power_control <= i_mgmt_wdata;
    end
  end

  // strap overlays the clock direction bit ahead of any write
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      interface_combo_control <= pecb_pkg::RST_IF_COMBO;
    end else if (i_ce) begin
      if (!strap_taken) begin
        interface_combo_control[pecb_pkg::CLOCK_DIR_BIT] <=
          i_strap_clk_dir;
      end else if (ext_wr &&
                   indirect_address_reg == pecb_pkg::EXT_IF_COMBO) begin
        interface_combo_control <= i_mgmt_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pad_control <= pecb_pkg::RST_PAD_CONTROL;
    end else if (i_ce && ext_wr &&
                 indirect_address_reg == pecb_pkg::EXT_PAD_CONTROL) begin
      pad_control <= i_mgmt_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      secondary_combo_control <= pecb_pkg::RST_COMBO2;
    end else if (i_ce && ext_wr &&
                 indirect_address_reg == pecb_pkg::EXT_COMBO2) begin
      secondary_combo_control <= i_mgmt_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_address_high   <= pecb_pkg::RST_WAKE_ADDR;
      wake_address_middle <= pecb_pkg::RST_WAKE_ADDR;
      wake_address_low    <= pecb_pkg::RST_WAKE_ADDR;
    end else if (i_ce && ext_wr) begin
      if (indirect_address_reg == pecb_pkg::EXT_WAKE_ADDR_HIGH) begin
        wake_address_high <= i_mgmt_wdata;
      end
      if (indirect_address_reg == pecb_pkg::EXT_WAKE_ADDR_MID) begin
        wake_address_middle <= i_mgmt_wdata;
      end
      if (indirect_address_reg == pecb_pkg::EXT_WAKE_ADDR_LOW) begin
        wake_address_low <= i_mgmt_wdata;
      end
    end
  end

  // extended read mux; unmapped addresses read as zero
  always_comb begin
    ext_hit   = 1'b1;
    ext_rdata = 16'h0000;
    unique case (indirect_address_reg)
      pecb_pkg::EXT_TEN_MEG_POWER:  ext_rdata = ten_meg_power_control;
      pecb_pkg::EXT_IF_COMBO:       ext_rdata = interface_combo_control;
      pecb_pkg::EXT_PAD_CONTROL:    ext_rdata = pad_control;
      pecb_pkg::EXT_COMBO2:         ext_rdata = secondary_combo_control;
      pecb_pkg::EXT_WAKE_ADDR_HIGH: ext_rdata = wake_address_high;
      pecb_pkg::EXT_WAKE_ADDR_MID:  ext_rdata = wake_address_middle;
      pecb_pkg::EXT_WAKE_ADDR_LOW:  ext_rdata = wake_address_low;
      default:                      ext_hit   = 1'b0;
    endcase
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (i_mgmt_regad == pecb_pkg::MGMT_INDIRECT_ADDR) begin
      next_rdata = indirect_address_reg;
    end else if (i_mgmt_regad == pecb_pkg::MGMT_INDIRECT_DATA &&
                 ext_hit) begin
      next_rdata = ext_rdata;
    end
  end

  // read data is held until the next read
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mgmt_rdata    <= 16'h0000;
      o_mgmt_rd_valid <= 1'b0;
    end else if (i_ce) begin
      o_mgmt_rd_valid <= i_mgmt_rd_en;
      if (i_mgmt_rd_en) begin
        o_mgmt_rdata <= next_rdata;
      end
    end
  end

  always_comb begin
    unique case ({interface_combo_control[pecb_pkg::REDUCED_IF_BIT],
                  clock_dir_in})
      2'h0: mode = pecb_pkg::PECB_MODE_MII;
      2'h1: mode = pecb_pkg::PECB_MODE_REVERSE_REDUCED;
      2'h2: mode = pecb_pkg::PECB_MODE_SECOND_REDUCED;
      2'h3: mode = pecb_pkg::PECB_MODE_FIRST_REDUCED;
    endcase
  end

  // datapath configuration outputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dac_power_down    <= 1'b0;
      o_far_loop_en       <= 1'b0;
      o_long_frame_en     <= 1'b0;
      o_frame_limit_bytes <= pecb_pkg::SHORT_FRAME_BYTES;
      o_crs_dv_pad        <= 1'b0;
      o_wake_detect_en    <= 1'b0;
      o_mac_if_mode       <= 2'h0;
      o_rxclk_from_dac    <= 1'b0;
    end else if (i_ce) begin
      o_dac_power_down <= idle_dac_shutoff_en && i_speed_10m &&
                          !i_tx_activity;
      o_far_loop_en <=
        interface_combo_control[pecb_pkg::FAR_LOOP_BIT];
      o_long_frame_en <=
        interface_combo_control[pecb_pkg::LONG_FRAME_BIT];
      o_frame_limit_bytes <=
        interface_combo_control[pecb_pkg::LONG_FRAME_BIT] ?
        pecb_pkg::LONG_FRAME_BYTES : pecb_pkg::SHORT_FRAME_BYTES;
      o_crs_dv_pad <= carrier_pad_source_sel ? i_rx_dv
                                             : i_crs_dv_int;
      o_wake_detect_en <= wake_detect_enable;
      o_mac_if_mode    <= mode;
      o_rxclk_from_dac <=
        secondary_combo_control[pecb_pkg::JITTER_TEST_BIT];
    end
  end

  // scan mode owns the pads, so the fields are overridden there
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mac_if_drive_strength   <= pecb_pkg::SCAN_DRIVE_STRENGTH;
      o_mgmt_pin_drive_strength <= pecb_pkg::SCAN_DRIVE_STRENGTH;
    end else if (i_ce) begin
      o_mac_if_drive_strength <= i_scan_mode ?
        pecb_pkg::SCAN_DRIVE_STRENGTH :
        pad_control[pecb_pkg::MAC_DRIVE_LSB +: 2];
      o_mgmt_pin_drive_strength <= i_scan_mode ?
        pecb_pkg::SCAN_DRIVE_STRENGTH :
        pad_control[pecb_pkg::MGMT_DRIVE_LSB +: 2];
    end
  end

  // under isolate a cleared bit freezes whatever direction was in use
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_txclk_is_input <= 1'b0;
    end else if (i_ce) begin
      if (!i_isolate) begin
        o_txclk_is_input <= clock_dir_in;
      end else if (isolate_tx_clock_input) begin
        o_txclk_is_input <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rxclk_is_input <= 1'b0;
    end else if (i_ce) begin
      if (!i_isolate) begin
        o_rxclk_is_input <= clock_dir_in;
      end else if (isolate_rx_clock_input) begin
        o_rxclk_is_input <= 1'b1;
      end
    end
  end

  // wake match against the stored 48-bit address
  assign wake_event = wake_detect_enable && i_wake_pkt_valid &&
                      (i_wake_pkt_dest == wake_addr);

  // level form: set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_level <= 1'b0;
    end else if (i_ce) begin
      if (wake_event) begin
        wake_level <= 1'b1;
      end else if (i_wake_irq_clear || !wake_detect_enable) begin
        wake_level <= 1'b0;
      end
    end
  end

  pecb_wake_pulse #(
    .CYC_A (WAKE_CYC_A),
    .CYC_B (WAKE_CYC_B),
    .CYC_C (WAKE_CYC_C),
    .CYC_D (WAKE_CYC_D)
  ) u_wake_pulse (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_fire      (wake_event),
    .i_width_sel (wake_irq_shape_sel[2:1]),
    .o_active    (wake_pulse)
  );

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wake_irq <= 1'b0;
    end else if (i_ce) begin
      o_wake_irq <= wake_irq_shape_sel[0] ? wake_pulse
                                          : wake_level;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_led0_is_irq <= 1'b0;
      o_led0_irq    <= 1'b0;
    end else if (i_ce) begin
      o_led0_is_irq <= irq_strap;
      if (!irq_strap) begin
        o_led0_irq <= 1'b0;
      end else if (irq_pin_source_sel) begin
        o_led0_irq <= i_general_irq;
      end else begin
        o_led0_irq <= wake_level | wake_pulse;
      end
    end
  end

  assign o_wake_match_addr = wake_addr;

endmodule : pecb_ext_bank

// [tb/pecb_mac_model.sv]
`timescale 1ns/1ps
module pecb_mac_model (
  input  wire logic        i_clk_sys,
  output logic             o_rx_dv,
  output logic             o_crs_dv,
  output logic             o_pkt_valid,
  output logic [47:0]      o_pkt_dest
);
  initial begin
    o_rx_dv     = 1'b0;
    o_crs_dv    = 1'b0;
    o_pkt_valid = 1'b0;
    o_pkt_dest  = 48'h0;
  end

  task automatic carrier(input logic dv, input logic crs);
    @(posedge i_clk_sys);
    o_rx_dv  <= dv;
    o_crs_dv <= crs;
  endtask : carrier

  // dest is inverted once the strobe drops, so a stale match cannot pass
  task automatic send(input logic [47:0] dst);
    @(posedge i_clk_sys);
    o_pkt_valid <= 1'b1;
    o_pkt_dest  <= dst;
    @(posedge i_clk_sys);
    o_pkt_valid <= 1'b0;
    o_pkt_dest  <= ~dst;
  endtask : send
endmodule : pecb_mac_model

// [tb/pecb_ext_bank_sva.sv]
`timescale 1ns/1ps
module pecb_ext_bank_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        i_ce,
  input wire logic        i_mgmt_rd_en,
  input wire logic        i_tx_activity,
  input wire logic        i_isolate,
  input wire logic        i_scan_mode,
  input wire logic        i_rx_dv,
  input wire logic        i_crs_dv_int,
  input wire logic        i_wake_pkt_valid,
  input wire logic        o_mgmt_rd_valid,
  input wire logic        o_dac_power_down,
  input wire logic        o_long_frame_en,
  input wire logic [14:0] o_frame_limit_bytes,
  input wire logic        o_crs_dv_pad,
  input wire logic [1:0]  o_mac_if_mode,
  input wire logic        o_txclk_is_input,
  input wire logic        o_rxclk_is_input,
  input wire logic [1:0]  o_mac_if_drive_strength,
  input wire logic [1:0]  o_mgmt_pin_drive_strength,
  input wire logic        o_led0_is_irq,
  input wire logic        o_led0_irq,
  input wire logic        o_wake_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_dac_on_tx: assert property (
    i_ce && i_tx_activity |=> !o_dac_power_down)
    else $error("dac powered down while sending");
  a_pad_source: assert property (
    i_ce && i_rx_dv == i_crs_dv_int |=> o_crs_dv_pad == $past(i_rx_dv))
    else $error("carrier pad not from its sources");
  a_frame_limit: assert property (
    o_frame_limit_bytes == (o_long_frame_en ? 15'h4800 : 15'h1200))
    else $error("frame limit disagrees with long frame enable");
  a_clk_dir_mode: assert property (
    $past(i_resetn) && !$past(i_isolate)
    |-> o_txclk_is_input == o_mac_if_mode[0]
        && o_rxclk_is_input == o_mac_if_mode[0])
    else $error("clock direction differs from mode low bit");
  a_scan_drive: assert property (
    i_ce && i_scan_mode |=> o_mac_if_drive_strength == 2'h3
        && o_mgmt_pin_drive_strength == 2'h3)
    else $error("drive strength not forced in scan");
  a_led_strap: assert property (o_led0_irq |-> o_led0_is_irq)
    else $error("led0 interrupt without strap");
  a_tx_iso_hold: assert property (
    i_ce && i_isolate && o_txclk_is_input |=> o_txclk_is_input)
    else $error("tx clock left input during isolate");
  a_rx_iso_hold: assert property (
    i_ce && i_isolate && o_rxclk_is_input |=> o_rxclk_is_input)
    else $error("rx clock left input during isolate");
  a_read_answer: assert property (
    i_ce && i_mgmt_rd_en |=> o_mgmt_rd_valid)
    else $error("read not answered next cycle");
  a_wake_cause: assert property (
    $rose(o_wake_irq) |-> $past(i_wake_pkt_valid, 2))
    else $error("wake interrupt without packet");

  c_read: cover property (o_mgmt_rd_valid);
  c_wake: cover property ($rose(o_wake_irq));
  c_scan: cover property (i_scan_mode && o_mgmt_pin_drive_strength == 2'h3);
endmodule : pecb_ext_bank_chk

bind pecb_ext_bank pecb_ext_bank_chk u_chk (.*);

// [tb/pecb_ext_bank_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module pecb_ext_bank_tb;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic [9:0]  e;
  } pecb_row_s;
  // field outputs accumulate over rows, so order matters
  localparam pecb_row_s ROWS [9] = '{
    '{16'h4000, 16'h0800, 10'h20B}, '{16'h4000, 16'h0026, 10'h1CB},
    '{16'h4000, 16'h0003, 10'h06B}, '{16'h4000, 16'h0001, 10'h02B},
    '{16'h4003, 16'h4000, 10'h03B}, '{16'h4001, 16'h0014, 10'h035},
    '{16'h4004, 16'hA1B2, 10'h035}, '{16'h4005, 16'hC3D4, 10'h035},
    '{16'h4006, 16'hE5F6, 10'h035}};
  localparam logic [15:0] RA [7] = '{16'h200A, 16'h4000, 16'h4001,
    16'h4003, 16'h4004, 16'h4005, 16'h4006};
  localparam logic [15:0] RV [7] = '{16'hCA02, 16'h0001, 16'h80EF,
    16'h0260, 16'h0000, 16'h0000, 16'h0000};
  logic        i_clk_sys = 1'b0;
  logic        i_resetn, i_ce, i_mgmt_wr_en, i_mgmt_rd_en, i_strap_clk_dir;
  logic        i_strap_rxd1, i_speed_10m, i_tx_activity, i_isolate;
  logic        i_scan_mode, i_rx_dv, i_crs_dv_int, i_general_irq;
  logic        i_wake_pkt_valid, i_wake_irq_clear;
  logic [4:0]  i_mgmt_regad;
  logic [15:0] i_mgmt_wdata, o_mgmt_rdata, d;
  logic [47:0] i_wake_pkt_dest, o_wake_match_addr;
  logic        o_mgmt_rd_valid, o_dac_power_down, o_far_loop_en;
  logic        o_long_frame_en, o_crs_dv_pad, o_wake_detect_en;
  logic        o_txclk_is_input, o_rxclk_is_input, o_rxclk_from_dac;
  logic        o_led0_is_irq, o_led0_irq, o_wake_irq;
  logic [14:0] o_frame_limit_bytes;
  logic [1:0]  o_mac_if_mode, o_mac_if_drive_strength;
  logic [1:0]  o_mgmt_pin_drive_strength;
  wire  [9:0]  obs = {o_far_loop_en, o_long_frame_en, o_wake_detect_en,
    o_mac_if_mode, o_rxclk_from_dac, o_mac_if_drive_strength,
    o_mgmt_pin_drive_strength};
  int          fails = 0;
  int          n_compared = 0;
  int          hi;

  always #12.5 i_clk_sys = ~i_clk_sys;

  // short pulse widths keep the run brief
  pecb_ext_bank #(.WAKE_CYC_A(4), .WAKE_CYC_B(8), .WAKE_CYC_C(12),
    .WAKE_CYC_D(16)) dut (.*);
  pecb_mac_model mac (.i_clk_sys, .o_rx_dv(i_rx_dv),
    .o_crs_dv(i_crs_dv_int), .o_pkt_valid(i_wake_pkt_valid),
    .o_pkt_dest(i_wake_pkt_dest));

  task automatic mg(input logic [4:0] a, input logic [15:0] wd);
    @(posedge i_clk_sys);
    i_mgmt_regad <= a;
    i_mgmt_wdata <= wd;
    i_mgmt_wr_en <= 1'b1;
    @(posedge i_clk_sys);
    i_mgmt_wr_en <= 1'b0;
  endtask : mg

  task automatic mr(input logic [4:0] a, output logic [15:0] rd);
    @(posedge i_clk_sys);
    i_mgmt_regad <= a;
    i_mgmt_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_mgmt_rd_en <= 1'b0;
    #1;
    `CHK(o_mgmt_rd_valid, 1'b1)
    rd = o_mgmt_rdata;
  endtask : mr

  task automatic xw(input logic [15:0] a, input logic [15:0] wd);
    mg(5'h1E, a);
    mg(5'h1F, wd);
  endtask : xw

  task automatic xr(input logic [15:0] a, output logic [15:0] rd);
    mg(5'h1E, a);
    mr(5'h1F, rd);
  endtask : xr

  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask : settle

  task automatic wake(input logic [47:0] dst, input int lim);
    mac.send(dst);
    hi = 0;
    repeat (lim) begin
      @(posedge i_clk_sys);
      #1;
      if (o_wake_irq === 1'b1) hi++;
    end
  endtask : wake

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    #1ms;
    fails++;
    print_verdict();
  end

  initial begin
    {i_resetn, i_mgmt_wr_en, i_mgmt_rd_en, i_mgmt_regad} = '0;
    {i_speed_10m, i_tx_activity, i_isolate, i_scan_mode} = '0;
    {i_general_irq, i_wake_irq_clear, i_mgmt_wdata} = '0;
    {i_ce, i_strap_clk_dir, i_strap_rxd1} = 3'h7;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    settle();
    `CHK(obs[3:0], 4'hB)
    `CHK({o_mac_if_mode, o_led0_is_irq}, 3'h3)
    for (int i = 0; i < 7; i++) begin
      xr(RA[i], d);
      `CHK(d, RV[i])
    end
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      xw(ROWS[i].a, ROWS[i].d);
      settle();
      `CHK(obs, ROWS[i].e)
      `CHK(o_frame_limit_bytes, ROWS[i].e[8] ? 15'h4800 : 15'h1200)
      xr(ROWS[i].a, d);
      `CHK(d, ROWS[i].d)
    end
    `CHK(o_wake_match_addr, 48'hA1B2C3D4E5F6)
    $display("test table done");
    xw(16'h4002, 16'hFFFF);
    xr(16'h4002, d);
    `CHK(d, 16'h0000)
    mr(5'h05, d);
    `CHK(d, 16'h0000)
    mr(5'h1E, d);
    `CHK(d, 16'h4002)
    $display("test unmapped done");
    @(posedge i_clk_sys) i_speed_10m <= 1'b1;
    xw(16'h200A, 16'hCE02);
    settle();
    `CHK(o_dac_power_down, 1'b1)
    @(posedge i_clk_sys) i_tx_activity <= 1'b1;
    settle();
    `CHK(o_dac_power_down, 1'b0)
    @(posedge i_clk_sys) i_tx_activity <= 1'b0;
    xw(16'h200A, 16'hCA02);
    settle();
    `CHK(o_dac_power_down, 1'b0)
    $display("test idle dac done");
    xw(16'h4000, 16'h0015);
    mac.carrier(1'b1, 1'b0);
    settle();
    `CHK(o_crs_dv_pad, 1'b1)
    wake(48'h0, 4);
    `CHK(hi, 0)
    wake(48'hA1B2C3D4E5F6, 4);
    `CHK({o_wake_irq, o_led0_irq}, 2'h3)
    @(posedge i_clk_sys) i_wake_irq_clear <= 1'b1;
    @(posedge i_clk_sys) i_wake_irq_clear <= 1'b0;
    settle();
    `CHK(o_wake_irq, 1'b0)
    for (int s = 0; s < 4; s++) begin
      xw(16'h4003, 16'h0080 | (16'(s) << 8));
      wake(48'hA1B2C3D4E5F6, 30);
      `CHK(hi, 4 * (s + 1))
    end
    xw(16'h4000, 16'h0001);
    settle();
    `CHK(o_crs_dv_pad, 1'b0)
    wake(48'hA1B2C3D4E5F6, 8);
    `CHK(hi, 0)
    $display("test wake done");
    xw(16'h4000, 16'h0000);
    xw(16'h4003, 16'h0040);
    i_isolate <= 1'b1;
    settle();
    `CHK({o_txclk_is_input, o_rxclk_is_input}, 2'h2)
    @(posedge i_clk_sys) i_scan_mode <= 1'b1;
    settle();
    `CHK(obs[3:0], 4'hF)
    $display("test isolate scan done");
    @(posedge i_clk_sys) i_general_irq <= 1'b1;
    xw(16'h4001, 16'h8014);
    settle();
    `CHK(o_led0_irq, 1'b1)
    // writes made while the enable is low must be lost
    @(posedge i_clk_sys) i_ce <= 1'b0;
    xw(16'h4001, 16'h0000);
    @(posedge i_clk_sys) i_ce <= 1'b1;
    settle();
    `CHK(o_led0_irq, 1'b1)
    xr(16'h4001, d);
    `CHK(d, 16'h8014)
    // second reset with both straps low
    @(posedge i_clk_sys) {i_resetn, i_strap_clk_dir, i_strap_rxd1} <= 3'h0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    settle();
    `CHK({o_mac_if_mode, o_led0_is_irq, o_led0_irq}, 4'h0)
    xr(16'h4000, d);
    `CHK(d, 16'h0000)
    xr(16'h4001, d);
    `CHK(d, 16'h80EF)
    $display("test enable reset done");
    print_verdict();
  end
endmodule : pecb_ext_bank_tb
